// ==== dv/adcss_top_tb.sv ====
`timescale 1ns/1ps
module adcss_top_tb;
	logic core_clk;
	logic nrst;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [adcss_pkg::BG_W-1:0] bg_request;
	logic [adcss_pkg::BG_W-1:0] consumer_enabled;
	logic [adcss_pkg::HIT_W-1:0] buf_written;
	logic [adcss_pkg::HIT_W-1:0] ch_match;
	logic converting;
	logic conv_done;
	logic [adcss_pkg::BG_W-1:0] bg_ref_en;
	logic [1:0] compare_mode;
	logic scan_active;
	logic [adcss_pkg::CH_IDX_W-1:0] scan_channel;
	logic current_source_connect;
	logic conv_clk_tick;
	logic irq;
	int bad_count;
	int checks_done;
	logic [31:0] rv;
	logic [31:0] hrdata_small;

	// single slave, so its ready is the bus ready
	adcss_top u_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bg_request(bg_request),
		.consumer_enabled(consumer_enabled), .buf_written(buf_written), .ch_match(ch_match),
		.converting(converting), .conv_done(conv_done), .bg_ref_en(bg_ref_en),
		.compare_mode(compare_mode), .scan_active(scan_active), .scan_channel(scan_channel),
		.current_source_connect(current_source_connect), .conv_clk_tick(conv_clk_tick),
		.irq(irq));

	// narrow package variant on the same bus; only its read data is watched
	adcss_top #(.SMALL_PKG(1'b1)) u_small (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata_small), .hreadyout(), .hresp(),
		.bg_request(bg_request), .consumer_enabled(consumer_enabled),
		.buf_written(buf_written), .ch_match(ch_match), .converting(converting),
		.conv_done(conv_done), .bg_ref_en(), .compare_mode(), .scan_active(),
		.scan_channel(), .current_source_connect(), .conv_clk_tick(), .irq());

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic conclude();
		if (bad_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// master holds each phase until ready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		rd = hrdata;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, a, d, dummy);
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		xfer(1'b0, a, 32'h00000000, got);
		chk(what, exp, got);
	endtask

	task automatic pulse(input logic [25:0] bw, input logic [25:0] cm);
		buf_written <= bw;
		ch_match <= cm;
		@(posedge core_clk);
		buf_written <= '0;
		ch_match <= '0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_reset_and_map();
		rchk("bg_cfg", adcss_pkg::OFS_BG_CFG, 32'h00000000);
		rchk("sel_lo", adcss_pkg::OFS_SEL_LO, 32'h00000000);
		rchk("hit_hi", adcss_pkg::OFS_HIT_HI, 32'h00000000);
		wreg(adcss_pkg::OFS_SEL_HI, 32'hFFFFFFFF);
		rchk("sel_hi", adcss_pkg::OFS_SEL_HI, 32'h0000F3FF);
		chk("small sel_hi", 32'h0000F300, hrdata_small);
		wreg(adcss_pkg::OFS_CTM_HI, 32'hFFFFFFFF);
		rchk("ctm_hi", adcss_pkg::OFS_CTM_HI, 32'h0000F3FF);
		chk("small ctm_hi", 32'h0000F300, hrdata_small);
		wreg(adcss_pkg::OFS_HIT_HI, 32'hFFFFFFFF);
		rchk("hit_hi", adcss_pkg::OFS_HIT_HI, 32'h000003FF);
		chk("small hit_hi", 32'h00000300, hrdata_small);
		wreg(adcss_pkg::OFS_SEL_LO, 32'hFFFFFFFF);
		rchk("sel_lo", adcss_pkg::OFS_SEL_LO, 32'h0000FFFF);
		wreg(8'h3C, 32'hFFFFFFFF);
		rchk("unmapped", 8'h3C, 32'h00000000);
		chk("hresp", 32'h00000000, {31'h0, hresp});
		wreg(adcss_pkg::OFS_SEL_HI, 32'h00000000);
		wreg(adcss_pkg::OFS_CTM_HI, 32'h00000000);
		wreg(adcss_pkg::OFS_HIT_HI, 32'h00000000);
		wreg(adcss_pkg::OFS_SEL_LO, 32'h00000000);
	endtask

	task automatic t_bandgap();
		consumer_enabled <= 6'h3F;
		for (int i = 0; i < adcss_pkg::BG_W; i++) begin
			wreg(adcss_pkg::OFS_BG_CFG, 32'h1 << i);
			repeat (2) @(posedge core_clk);
			chk("bg_ref_en", 32'h1 << i, {26'h0, bg_ref_en});
		end
		wreg(adcss_pkg::OFS_BG_CFG, 32'h00000021);
		bg_request <= 6'h02;
		repeat (2) @(posedge core_clk);
		chk("bg_ref_en", 32'h00000023, {26'h0, bg_ref_en});
		// disabled consumers drop their reference whatever the manual bits say
		consumer_enabled <= 6'h1E;
		repeat (2) @(posedge core_clk);
		chk("bg_ref_en", 32'h00000002, {26'h0, bg_ref_en});
		rchk("bg_cfg", adcss_pkg::OFS_BG_CFG, 32'h00000021);
		bg_request <= 6'h00;
	endtask

	task automatic t_hits();
		for (int m = 0; m < 4; m++) begin
			wreg(adcss_pkg::OFS_SCAN_CTRL, m);
			// the copy is launched at the write edge; look one edge later
			@(posedge core_clk);
			chk("compare_mode", m, {30'h0, compare_mode});
		end
		wreg(adcss_pkg::OFS_SCAN_CTRL, 32'h00000000);
		wreg(adcss_pkg::OFS_IRQ_MASK, 32'h00000001);
		pulse(26'h0000008, 26'h0100000);
		rchk("hit_lo", adcss_pkg::OFS_HIT_LO, 32'h00000000);
		rchk("hit_hi", adcss_pkg::OFS_HIT_HI, 32'h00000010);
		chk("irq", 32'h00000001, {31'h0, irq});
		wreg(adcss_pkg::OFS_SCAN_CTRL, 32'h00000003);
		pulse(26'h0000002, 26'h0000000);
		rchk("hit_lo", adcss_pkg::OFS_HIT_LO, 32'h00000002);
		rchk("hit_hi", adcss_pkg::OFS_HIT_HI, 32'h00000010);
		wreg(adcss_pkg::OFS_HIT_LO, 32'h00000080);
		rchk("hit_lo", adcss_pkg::OFS_HIT_LO, 32'h00000080);
		rchk("irq_sts", adcss_pkg::OFS_IRQ_STS, 32'h00000001);
		wreg(adcss_pkg::OFS_IRQ_STS, 32'h00000001);
		rchk("irq_sts", adcss_pkg::OFS_IRQ_STS, 32'h00000000);
		chk("irq", 32'h00000000, {31'h0, irq});
		wreg(adcss_pkg::OFS_IRQ_MASK, 32'h00000000);
		pulse(26'h0000000, 26'h0000001);
		chk("irq masked", 32'h00000000, {31'h0, irq});
		rchk("irq_sts", adcss_pkg::OFS_IRQ_STS, 32'h00000001);
	endtask

	task automatic t_scan();
		wreg(adcss_pkg::OFS_CTM_LO, 32'h00000004);
		wreg(adcss_pkg::OFS_SEL_LO, 32'h00000005);
		wreg(adcss_pkg::OFS_SCAN_CTRL, 32'h00008000);
		converting <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("scan_active", 32'h00000001, {31'h0, scan_active});
		chk("scan_channel", 32'h00000000, {27'h0, scan_channel});
		chk("ctm connect", 32'h00000000, {31'h0, current_source_connect});
		conv_done <= 1'b1;
		@(posedge core_clk);
		conv_done <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("scan_channel", 32'h00000002, {27'h0, scan_channel});
		chk("ctm connect", 32'h00000001, {31'h0, current_source_connect});
		conv_done <= 1'b1;
		@(posedge core_clk);
		conv_done <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("scan_channel", 32'h00000000, {27'h0, scan_channel});
		rchk("irq_sts", adcss_pkg::OFS_IRQ_STS, 32'h00000003);
		converting <= 1'b0;
		wreg(adcss_pkg::OFS_SCAN_CTRL, 32'h00000000);
		repeat (2) @(posedge core_clk);
		chk("scan_active", 32'h00000000, {31'h0, scan_active});
	endtask

	task automatic t_conv_clock();
		int n;
		wreg(adcss_pkg::OFS_CLK_CFG, 32'h00000003);
		// let the old count run out before timing a full period
		repeat (20) @(posedge core_clk);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (conv_clk_tick !== 1'b1 && n < 100);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (conv_clk_tick !== 1'b1 && n < 100);
		chk("tick period", adcss_pkg::OSC_PER_TCY * 4, n);
	endtask

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		bg_request = 6'h00;
		consumer_enabled = 6'h00;
		buf_written = '0;
		ch_match = '0;
		converting = 1'b0;
		conv_done = 1'b0;
		bad_count = 0;
		checks_done = 0;
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		chk("hreadyout", 32'h00000001, {31'h0, hreadyout});
		t_reset_and_map();
		t_bandgap();
		t_hits();
		t_scan();
		t_conv_clock();
		conclude();
	end

	initial begin
		#200000;
		bad_count++;
		conclude();
	end
endmodule

// ==== logic/adcss_pkg.sv ====
package adcss_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_BG_CFG = 8'h00;
	localparam logic [7:0] OFS_HIT_HI = 8'h04;
	localparam logic [7:0] OFS_HIT_LO = 8'h08;
	localparam logic [7:0] OFS_SEL_HI = 8'h0C;
	localparam logic [7:0] OFS_SEL_LO = 8'h10;
	localparam logic [7:0] OFS_CTM_HI = 8'h14;
	localparam logic [7:0] OFS_CTM_LO = 8'h18;
	localparam logic [7:0] OFS_SCAN_CTRL = 8'h1C;
	localparam logic [7:0] OFS_CLK_CFG = 8'h20;
	localparam logic [7:0] OFS_IRQ_STS = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	localparam int BG_W = 6;
	localparam int BG_USB_DIV6_BIT = 5;
	localparam int BG_CMP_DIV2_BIT = 4;
	localparam int BG_DAC_BIT = 3;
	localparam int BG_ANALOG_BIT = 2;
	localparam int BG_ADC_BIT = 1;
	localparam int BG_GENERAL_BIT = 0;
	localparam int HIT_W = 26;
	localparam int HIT_HI_W = 10;
	localparam int CH_W = 32;
	localparam int CH_IDX_W = 5;
	localparam logic [31:0] CH_IMPL_MASK = 32'hF3FF_FFFF;
	localparam logic [31:0] CH_SMALL_PKG_HOLE = 32'h00FF_0000;
	localparam int AUTO_SCAN_BIT = 15;
	localparam int CM_LSB = 0;
	localparam logic [1:0] CM_LESS = 2'h0;
	localparam logic [1:0] CM_GREATER = 2'h1;
	localparam logic [1:0] CM_INSIDE = 2'h2;
	localparam logic [1:0] CM_OUTSIDE = 2'h3;
	localparam int DIV_W = 8;
	localparam int IRQ_W = 2;
	localparam int IRQ_HIT_BIT = 0;
	localparam int IRQ_SCAN_BIT = 1;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int CORE_CLK_PS = 10000;
	localparam int OSC_PER_TCY = 2;
	localparam int TCY_PS = OSC_PER_TCY * CORE_CLK_PS;
	localparam int TCY_CLKS = TCY_PS / CORE_CLK_PS;
	localparam int PH_W = 2;
	typedef enum logic [1:0] {
		ADCSS_SCAN_IDLE = 2'h0,
		ADCSS_SCAN_RUN = 2'h1
	} adcss_scan_e;
endpackage

// ==== logic/adcss_tad_gen.sv ====
`timescale 1ns/1ps
module adcss_tad_gen (
	input wire logic core_clk,
	input wire logic nrst,
	adcss_tad_if.gen tad
);
	typedef struct packed {
		logic [adcss_pkg::PH_W-1:0] ph;
		logic [adcss_pkg::DIV_W-1:0] cnt;
		logic tick;
	} adcss_tad_s;
	localparam logic [adcss_pkg::PH_W-1:0] PH_LAST = adcss_pkg::PH_W'(adcss_pkg::TCY_CLKS - 1);
	adcss_tad_s st_ff;
	adcss_tad_s nxt_st;
	logic tcy_tick;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		tcy_tick = (st_ff.ph == PH_LAST);
		if (tcy_tick) begin
			nxt_st.ph = '0;
			// >= so a divider shrunk mid-count cannot run the counter past it
			if (st_ff.cnt >= tad.divider) begin
				nxt_st.cnt = '0;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end else begin
			nxt_st.ph = st_ff.ph + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tad.tad_tick = st_ff.tick;

	logic [11:0] gap_ff;
	logic seen_ff;
	logic div_chg_ff;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			gap_ff <= 12'h000;
			seen_ff <= 1'b0;
			div_chg_ff <= 1'b0;
		end else begin
			gap_ff <= st_ff.tick ? 12'h000 : gap_ff + 12'h001;
			seen_ff <= seen_ff | st_ff.tick;
			div_chg_ff <= st_ff.tick ? 1'b0 : (div_chg_ff | (tad.divider != $past(tad.divider)));
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	tad_period_a: assert property (st_ff.tick && seen_ff && !div_chg_ff && $stable(tad.divider)
		|-> gap_ff == 12'(adcss_pkg::TCY_CLKS * (int'(tad.divider) + 1) - 1))
		else $error("conversion clock period wrong");
	tcy_rate_a: assert property (tcy_tick |=> !tcy_tick ##1 tcy_tick)
		else $error("instruction cycle not two clocks");
	tad_tick_c: cover property (st_ff.tick && seen_ff);
endmodule

// ==== logic/adcss_tad_if.sv ====
`timescale 1ns/1ps
interface adcss_tad_if;
	logic [adcss_pkg::DIV_W-1:0] divider;
	logic tad_tick;
	modport gen (input divider, output tad_tick);
	modport ctl (output divider, input tad_tick);
endinterface

// ==== logic/adcss_top.sv ====
// Functional notes
// - bit 5 enables usb divide-by-six reference
// - bit 4 enables comparator divide-by-two reference
// - bits 3..0 manually enable full reference
// - consumer request turns reference on, disable off
// - mode 11: buffer write or match sets flag
// - other modes: only a match sets flag
// - low word flags 15..0, high 25..16
// - small package hides channels 16..23
// - scan converts selected channels, skips others
// - high select word layout, bits 11..10 zero
// - connect bit routes current source during conversion; code connects it only while the auto-scan sequencer runs
// - high connect word layout, bits 11..10 zero
// - conversion clock is divider plus one cycles
// - instruction cycle is two oscillator periods
// - compare mode selects match rule
// - scanning runs only with auto-scan enable set
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module adcss_top #(
	parameter bit SMALL_PKG = 1'b0
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [adcss_pkg::BG_W-1:0] bg_request,
	input wire logic [adcss_pkg::BG_W-1:0] consumer_enabled,
	input wire logic [adcss_pkg::HIT_W-1:0] buf_written,
	input wire logic [adcss_pkg::HIT_W-1:0] ch_match,
	input wire logic converting,
	input wire logic conv_done,
	output logic [adcss_pkg::BG_W-1:0] bg_ref_en,
	output logic [1:0] compare_mode,
	output logic scan_active,
	output logic [adcss_pkg::CH_IDX_W-1:0] scan_channel,
	output logic current_source_connect,
	output logic conv_clk_tick,
	output logic irq
);
	localparam logic [31:0] CH_MASK = SMALL_PKG ?
		(adcss_pkg::CH_IMPL_MASK & ~adcss_pkg::CH_SMALL_PKG_HOLE) : adcss_pkg::CH_IMPL_MASK;
	localparam logic [adcss_pkg::HIT_W-1:0] HIT_MASK = CH_MASK[adcss_pkg::HIT_W-1:0];

	typedef struct packed {
		logic [adcss_pkg::BG_W-1:0] bg_manual;
		logic [adcss_pkg::BG_W-1:0] bg_ref;
		logic [adcss_pkg::HIT_W-1:0] hit;
		logic [adcss_pkg::CH_W-1:0] sel;
		logic [adcss_pkg::CH_W-1:0] ctm;
		logic [1:0] cm;
		logic auto_scan;
		logic [adcss_pkg::DIV_W-1:0] div;
		logic [adcss_pkg::IRQ_W-1:0] ists;
		logic [adcss_pkg::IRQ_W-1:0] imask;
		adcss_pkg::adcss_scan_e scan;
		logic run;
		logic [adcss_pkg::CH_IDX_W-1:0] ch;
		logic ctm_conn;
		logic tad;
		logic irq;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic dwr;
		logic drd;
		logic [adcss_pkg::ADDR_W-1:0] daddr;
	} adcss_st_s;

	adcss_st_s st_ff;
	adcss_st_s nxt_st;
	adcss_tad_if tad_bus ();
	logic [adcss_pkg::HIT_W-1:0] hit_set;
	logic hit_sw_wr;
	logic scan_wrap;
	logic [5:0] nsel;

	// next selected channel after cur, wrapping; msb says one was found
	function automatic logic [5:0] next_sel(input logic [31:0] m, input logic [4:0] cur);
		logic [5:0] r;
		logic [4:0] idx;
		r = 6'h00;
		for (int i = 32; i >= 1; i--) begin
			idx = 5'(cur + 5'(i));
			if (m[idx]) begin
				r = {1'b1, idx};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] lo16(input logic [31:0] v);
		return {16'h0000, v[15:0]};
	endfunction

	function automatic logic [31:0] hi16(input logic [31:0] v);
		return {16'h0000, v[31:16]};
	endfunction

	adcss_tad_gen u_tad (
		.core_clk(core_clk),
		.nrst(nrst),
		.tad(tad_bus.gen)
	);
	assign tad_bus.divider = st_ff.div;

	always_comb begin
		nxt_st = st_ff;
		hit_sw_wr = 1'b0;
		scan_wrap = 1'b0;
		nsel = 6'h00;
		// data phase of a write: zero wait states, so hwdata lands now
		if (st_ff.dwr) begin
			case (st_ff.daddr)
				adcss_pkg::OFS_BG_CFG: begin
					nxt_st.bg_manual = hwdata[adcss_pkg::BG_W-1:0];
				end
				adcss_pkg::OFS_HIT_LO: begin
					nxt_st.hit[15:0] = hwdata[15:0] & HIT_MASK[15:0];
					hit_sw_wr = 1'b1;
				end
				adcss_pkg::OFS_HIT_HI: begin
					nxt_st.hit[adcss_pkg::HIT_W-1:16] = hwdata[adcss_pkg::HIT_HI_W-1:0]
						& HIT_MASK[adcss_pkg::HIT_W-1:16];
					hit_sw_wr = 1'b1;
				end
				adcss_pkg::OFS_SEL_LO: begin
					nxt_st.sel[15:0] = hwdata[15:0];
				end
				adcss_pkg::OFS_SEL_HI: begin
					nxt_st.sel[31:16] = hwdata[15:0] & CH_MASK[31:16];
				end
				adcss_pkg::OFS_CTM_LO: begin
					nxt_st.ctm[15:0] = hwdata[15:0];
				end
				adcss_pkg::OFS_CTM_HI: begin
					nxt_st.ctm[31:16] = hwdata[15:0] & CH_MASK[31:16];
				end
				adcss_pkg::OFS_SCAN_CTRL: begin
					nxt_st.auto_scan = hwdata[adcss_pkg::AUTO_SCAN_BIT];
					nxt_st.cm = hwdata[adcss_pkg::CM_LSB+:2];
				end
				adcss_pkg::OFS_CLK_CFG: begin
					nxt_st.div = hwdata[adcss_pkg::DIV_W-1:0];
				end
				adcss_pkg::OFS_IRQ_STS: begin
					nxt_st.ists = st_ff.ists & ~hwdata[adcss_pkg::IRQ_W-1:0];
				end
				adcss_pkg::OFS_IRQ_MASK: begin
					nxt_st.imask = hwdata[adcss_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// hardware set beats a software clear in the same cycle
		hit_set = ch_match & HIT_MASK;
		if (st_ff.cm == adcss_pkg::CM_OUTSIDE) begin
			hit_set = hit_set | (buf_written & HIT_MASK);
		end
		nxt_st.hit = nxt_st.hit | hit_set;
		// manual bits or a live request turn a reference on; a disabled consumer wins
		nxt_st.bg_ref = consumer_enabled & (st_ff.bg_manual | bg_request);
		// scan sequencer
		case (st_ff.scan)
			adcss_pkg::ADCSS_SCAN_IDLE: begin
				nsel = next_sel(st_ff.sel & CH_MASK, 5'h1F);
				if (st_ff.auto_scan && nsel[5]) begin
					nxt_st.scan = adcss_pkg::ADCSS_SCAN_RUN;
					nxt_st.ch = nsel[4:0];
				end
			end
			adcss_pkg::ADCSS_SCAN_RUN: begin
				nsel = next_sel(st_ff.sel & CH_MASK, st_ff.ch);
				if (!st_ff.auto_scan || !nsel[5]) begin
					nxt_st.scan = adcss_pkg::ADCSS_SCAN_IDLE;
				end else if (conv_done) begin
					nxt_st.ch = nsel[4:0];
					scan_wrap = (nsel[4:0] <= st_ff.ch);
				end
			end
			default: begin
				nxt_st.scan = adcss_pkg::ADCSS_SCAN_IDLE;
			end
		endcase
		// own flop so the scan_active pin stays a register output
		nxt_st.run = (nxt_st.scan == adcss_pkg::ADCSS_SCAN_RUN);
		nxt_st.ctm_conn = (st_ff.scan == adcss_pkg::ADCSS_SCAN_RUN) && converting
			&& st_ff.ctm[st_ff.ch] && CH_MASK[st_ff.ch];
		nxt_st.tad = tad_bus.tad_tick;
		nxt_st.ists = nxt_st.ists | {scan_wrap, |hit_set};
		nxt_st.irq = |(nxt_st.ists & nxt_st.imask);
		// address phase: read data built from the updated copy, so a
		// read right behind a write sees the new value
		nxt_st.dwr = 1'b0;
		nxt_st.drd = 1'b0;
		nxt_st.hreadyout = 1'b1;
		nxt_st.hresp = 1'b0;
		if (hsel && htrans[1] && hready) begin
			nxt_st.daddr = haddr[adcss_pkg::ADDR_W-1:0];
			nxt_st.dwr = hwrite;
			nxt_st.drd = !hwrite;
			if (!hwrite) begin
				case (haddr[adcss_pkg::ADDR_W-1:0])
					adcss_pkg::OFS_BG_CFG: begin
						// manual value only, never the live reference state
						nxt_st.hrdata = 32'(nxt_st.bg_manual);
					end
					adcss_pkg::OFS_HIT_LO: begin
						nxt_st.hrdata = {16'h0000, nxt_st.hit[15:0]};
					end
					adcss_pkg::OFS_HIT_HI: begin
						nxt_st.hrdata = 32'(nxt_st.hit[adcss_pkg::HIT_W-1:16]);
					end
					adcss_pkg::OFS_SEL_LO: begin
						nxt_st.hrdata = lo16(nxt_st.sel);
					end
					adcss_pkg::OFS_SEL_HI: begin
						nxt_st.hrdata = hi16(nxt_st.sel);
					end
					adcss_pkg::OFS_CTM_LO: begin
						nxt_st.hrdata = lo16(nxt_st.ctm);
					end
					adcss_pkg::OFS_CTM_HI: begin
						nxt_st.hrdata = hi16(nxt_st.ctm);
					end
					adcss_pkg::OFS_SCAN_CTRL: begin
						nxt_st.hrdata = 32'({nxt_st.auto_scan, 13'h0000, nxt_st.cm});
					end
					adcss_pkg::OFS_CLK_CFG: begin
						nxt_st.hrdata = 32'(nxt_st.div);
					end
					adcss_pkg::OFS_IRQ_STS: begin
						nxt_st.hrdata = 32'(nxt_st.ists);
					end
					adcss_pkg::OFS_IRQ_MASK: begin
						nxt_st.hrdata = 32'(nxt_st.imask);
					end
					default: begin
						nxt_st.hrdata = adcss_pkg::RST_WORD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.hreadyout <= 1'b1;
			st_ff.scan <= adcss_pkg::ADCSS_SCAN_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hrdata = st_ff.hrdata;
	assign hreadyout = st_ff.hreadyout;
	assign hresp = st_ff.hresp;
	assign bg_ref_en = st_ff.bg_ref;
	assign compare_mode = st_ff.cm;
	assign scan_active = st_ff.run;
	assign scan_channel = st_ff.ch;
	assign current_source_connect = st_ff.ctm_conn;
	assign conv_clk_tick = st_ff.tad;
	assign irq = st_ff.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	bg_usb_ref_a: assert property (##1 bg_ref_en[adcss_pkg::BG_USB_DIV6_BIT] ==
		$past(consumer_enabled[adcss_pkg::BG_USB_DIV6_BIT] && (bg_request[adcss_pkg::BG_USB_DIV6_BIT]
		|| st_ff.bg_manual[adcss_pkg::BG_USB_DIV6_BIT])))
		else $error("usb reference enable wrong");
	bg_cmp_ref_a: assert property ($past(st_ff.bg_manual[adcss_pkg::BG_CMP_DIV2_BIT]
		&& consumer_enabled[adcss_pkg::BG_CMP_DIV2_BIT]) |-> bg_ref_en[adcss_pkg::BG_CMP_DIV2_BIT])
		else $error("comparator reference not enabled");
	bg_full_ref_a: assert property ($past(consumer_enabled[3:0] & st_ff.bg_manual[3:0])
		== ($past(consumer_enabled[3:0] & st_ff.bg_manual[3:0]) & bg_ref_en[3:0]))
		else $error("manual reference enable lost");
	bg_off_a: assert property (!consumer_enabled[adcss_pkg::BG_DAC_BIT]
		|=> !bg_ref_en[adcss_pkg::BG_DAC_BIT])
		else $error("reference on while consumer disabled");
	hit_mode_write_a: assert property (st_ff.cm == adcss_pkg::CM_OUTSIDE && buf_written[0]
		|=> st_ff.hit[0])
		else $error("buffer write did not set flag");
	hit_match_only_a: assert property (st_ff.cm != adcss_pkg::CM_OUTSIDE && !ch_match[0]
		&& !st_ff.hit[0] && !(st_ff.dwr && st_ff.daddr == adcss_pkg::OFS_HIT_LO) |=> !st_ff.hit[0])
		else $error("flag set without match");
	hit_hi_read_a: assert property (st_ff.drd && st_ff.daddr == adcss_pkg::OFS_HIT_HI
		|-> hrdata[31:adcss_pkg::HIT_HI_W] == '0)
		else $error("hit high word upper bits not zero");
	small_pkg_a: assert property (SMALL_PKG |-> ((st_ff.sel | st_ff.ctm)
		& adcss_pkg::CH_SMALL_PKG_HOLE) == '0 && st_ff.hit[23:16] == '0)
		else $error("small package channel bits set");
	scan_selected_a: assert property ($rose(scan_active) |-> $past(st_ff.sel[st_ff.ch]
		|| st_ff.sel[nxt_st.ch])) else $error("scan started on unselected channel");
	sel_hole_a: assert property (st_ff.sel[27:26] == 2'h0 && st_ff.ctm[27:26] == 2'h0)
		else $error("unimplemented select bits set");
	ctm_conn_a: assert property (current_source_connect |-> $past(converting && scan_active
		&& st_ff.ctm[st_ff.ch])) else $error("current source connected wrongly");
	auto_off_a: assert property (!st_ff.auto_scan |=> !scan_active)
		else $error("scan runs with auto-scan clear");
	hit_sticky_a: assert property (st_ff.hit[0] && !hit_sw_wr |=> st_ff.hit[0])
		else $error("hit flag dropped without software write");
	irq_level_a: assert property (##1 irq == $past(|(nxt_st.ists & nxt_st.imask)))
		else $error("interrupt level wrong");

	// bus never stalls, so each read answer is judged in its data phase
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	read_upper_a: assert property (st_ff.drd |-> hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	bg_readback_a: assert property (st_ff.drd && st_ff.daddr == adcss_pkg::OFS_BG_CFG
		|-> hrdata == 32'(st_ff.bg_manual))
		else $error("reference read-back not the manual value");
	bg_cmp_off_a: assert property (!consumer_enabled[adcss_pkg::BG_CMP_DIV2_BIT]
		|=> !bg_ref_en[adcss_pkg::BG_CMP_DIV2_BIT])
		else $error("comparator reference on while consumer disabled");
	hit_clear_a: assert property (st_ff.dwr && st_ff.daddr == adcss_pkg::OFS_HIT_LO
		&& !hwdata[0] && !ch_match[0]
		&& !(st_ff.cm == adcss_pkg::CM_OUTSIDE && buf_written[0]) |=> !st_ff.hit[0])
		else $error("software clear of hit flag lost");
	ctm_idle_a: assert property (!converting |=> !current_source_connect)
		else $error("current source connected outside conversion");
	tick_copy_a: assert property (##1 conv_clk_tick == $past(tad_bus.tad_tick))
		else $error("conversion clock tick not passed on");
	wrap_flag_a: assert property (scan_wrap |=> st_ff.ists[adcss_pkg::IRQ_SCAN_BIT])
		else $error("scan wrap not flagged");
	ists_clear_a: assert property (st_ff.dwr && st_ff.daddr == adcss_pkg::OFS_IRQ_STS
		&& hwdata[adcss_pkg::IRQ_HIT_BIT] && !(|hit_set)
		|=> !st_ff.ists[adcss_pkg::IRQ_HIT_BIT])
		else $error("hit event status not cleared");
	hit_set_c: cover property (st_ff.cm == adcss_pkg::CM_OUTSIDE ##1 $rose(st_ff.hit[0]));
	scan_wrap_c: cover property (scan_active && scan_wrap);
	irq_c: cover property ($rose(irq));
	ctm_c: cover property ($rose(current_source_connect));
endmodule
